// *** design/sw_lock_consts.svh ***
// Behaviour
// - sticky unsupported-completion enable at bit 13
// - sticky three-bit marker survives hot reset
// - read-only lock state at bits 18:17
// - lock-blocked upstream packet dropped, sets bit 19
// - foreign locked read dropped, sets bit 19
// - bits 20-23 show aggregated INTA-INTD
// - packet to unlocked port dropped, flag 24
// - locked PME turn-off sets flag 25
// - writing one starts fundamental reset, reads zero
// - reset hold keeps switch logic in reset
// - software reset hold writes ignored after reset done unless hold is set
// - reset hold set by pin during reset operation, or by eeprom at any time
// - write unlock gates write-when-unlocked fields
// - write unlock set during reset operation
// - strict ordering bit overrides relaxed ordering
`ifndef SW_LOCK_CONSTS_SVH
`define SW_LOCK_CONSTS_SVH
`define OFS_SWITCH_STATUS 12'h0a0
`define OFS_SWITCH_CONTROL 12'h0a4
`define BIT_UC_EN 13
`define POS_MARKER 14
`define POS_LOCK 17
`define BIT_LOCK_DROP 19
`define POS_INT 20
`define BIT_LOCK_DISCARD 24
`define BIT_PME_LOCK 25
`define POS_MAX_WIDTH 30
`define RST_MAX_WIDTH 2'h0
`define BIT_SWRST 0
`define BIT_HOLD 1
`define BIT_UNLOCK 2
`define BIT_STRICT 3
`define RESET_OP_CYCLES 4'h8
`endif

// *** design/sw_lock_pkg.sv ***
package sw_lock_pkg;
	typedef enum logic [1:0] {
		LOCK_NONE = 2'h0,
		LOCK_PORT_B = 2'h1,
		LOCK_PORT_C = 2'h2,
		LOCK_RSVD = 2'h3
	} lock_state_t;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [11:0] addr;
		logic [31:0] wdata;
	} reg_req_t;
	typedef struct packed {
		logic up_blocked;
		logic foreign_mrdlk;
		logic to_unlocked_port;
		logic pme_turnoff_locked;
	} lock_evt_t;
endpackage

// *** design/switch_lock_status_control.sv ***
`timescale 1ns/1ns
`include "sw_lock_consts.svh"
module switch_lock_status_control
	import sw_lock_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic hot_rst,
	input wire logic reset_hold_pin,
	input wire logic eeprom_hold_wr,
	input wire logic eeprom_hold_val,
	input wire reg_req_t req,
	output logic [31:0] rdata,
	input wire lock_state_t lock_state,
	input wire lock_evt_t evt,
	input wire logic err_report_en,
	input wire logic [3:0] int_state,
	output logic err_nonfatal,
	output logic packet_drop,
	output logic fund_reset_req,
	output logic core_hold,
	output logic write_unlock,
	output logic strict_ordering_force,
	output logic unsupported_cpl_enable
);
	logic [1:0] pin_sync_r;
	logic [3:0] op_cnt_r;
	logic reset_op;
	logic uc_en_r;
	logic [2:0] marker_r;
	logic hold_r;
	logic unlock_r;
	logic strict_r;
	logic fund_r;
	logic drop_set, discard_set, pme_set;
	logic drop_q, discard_q, pme_q;
	logic wr_ctl, wr_sts, rd_hit;
	logic [31:0] sts_word, ctl_word;
	logic err_r;
	logic drop_r;
	logic is_locked;
	logic clr_drop, clr_discard, clr_pme;
	logic rd_sts, rd_ctl;
	logic [31:0] rd_word;
	logic hold_pin_set, hold_sw_ok;

	assign wr_ctl = req.wr && req.addr == `OFS_SWITCH_CONTROL;
	assign wr_sts = req.wr && req.addr == `OFS_SWITCH_STATUS;
	assign reset_op = op_cnt_r != 4'h0;
	assign rd_sts = req.rd && req.addr == `OFS_SWITCH_STATUS;
	assign rd_ctl = req.rd && req.addr == `OFS_SWITCH_CONTROL;
	assign is_locked = lock_state != LOCK_NONE;
	assign hold_pin_set = reset_op && pin_sync_r[1];
	assign hold_sw_ok = wr_ctl && (reset_op || hold_r);
	assign clr_drop = wr_sts && req.wdata[`BIT_LOCK_DROP];
	assign clr_discard = wr_sts && req.wdata[`BIT_LOCK_DISCARD];
	assign clr_pme = wr_sts && req.wdata[`BIT_PME_LOCK];

	always_ff @(posedge clk) begin
		pin_sync_r <= {pin_sync_r[0], reset_hold_pin};
	end

	// reset operation window after release
	always_ff @(posedge clk) begin
		if (rst || fund_r) begin
			op_cnt_r <= `RESET_OP_CYCLES;
		end else if (reset_op) begin
			op_cnt_r <= op_cnt_r - 4'h1;
		end
	end

	// sticky fields: only fundamental reset clears, hot reset ignored
	always_ff @(posedge clk) begin
		if (rst) begin
			uc_en_r <= 1'b0;
			marker_r <= 3'h0;
		end else if (wr_sts) begin
			uc_en_r <= req.wdata[`BIT_UC_EN];
			marker_r <= req.wdata[`POS_MARKER +: 3];
		end
	end

	// reset hold: pin during reset op, eeprom any time, sw during reset op or while held
	always_ff @(posedge clk) begin
		if (rst) begin
			hold_r <= 1'b0;
		end else if (hold_pin_set) begin
			hold_r <= 1'b1;
		end else if (eeprom_hold_wr) begin
			hold_r <= eeprom_hold_val;
		end else if (hold_sw_ok) begin
			hold_r <= req.wdata[`BIT_HOLD];
		end
	end

	always_ff @(posedge clk) begin
		if (rst || hot_rst) begin
			unlock_r <= 1'b0;
			strict_r <= 1'b0;
			fund_r <= 1'b0;
		end else begin
			fund_r <= wr_ctl && req.wdata[`BIT_SWRST];
			strict_r <= wr_ctl ? req.wdata[`BIT_STRICT] : strict_r;
			if (reset_op) begin
				unlock_r <= 1'b1;
			end else if (wr_ctl) begin
				unlock_r <= req.wdata[`BIT_UNLOCK];
			end
		end
	end

	assign drop_set = is_locked && (evt.up_blocked || evt.foreign_mrdlk);
	assign discard_set = is_locked && evt.to_unlocked_port;
	assign pme_set = is_locked && evt.pme_turnoff_locked;

	w1c_flag u_drop (
		.clk(clk),
		.rst(rst),
		.set(drop_set),
		.clr(clr_drop),
		.q(drop_q)
	);
	w1c_flag u_discard (
		.clk(clk),
		.rst(rst),
		.set(discard_set),
		.clr(clr_discard),
		.q(discard_q)
	);
	w1c_flag u_pme (
		.clk(clk),
		.rst(rst),
		.set(pme_set),
		.clr(clr_pme),
		.q(pme_q)
	);

	always_ff @(posedge clk) begin
		if (rst) begin
			err_r <= 1'b0;
			drop_r <= 1'b0;
		end else begin
			err_r <= err_report_en && (discard_set || pme_set);
			drop_r <= drop_set || discard_set;
		end
	end

	assign sts_word = {`RST_MAX_WIDTH, 4'h0, pme_q, discard_q, int_state, drop_q,
		lock_state, marker_r, uc_en_r, 13'h0000};
	assign ctl_word = {28'h0000000, strict_r, unlock_r, hold_r, 1'b0};
	assign rd_hit = req.rd;
	assign rd_word = rd_sts ? sts_word : (rd_ctl ? ctl_word : 32'h00000000);

	always_ff @(posedge clk) begin
		if (rst) begin
			rdata <= 32'h00000000;
		end else if (rd_hit) begin
			rdata <= rd_word;
		end
	end

	assign err_nonfatal = err_r;
	assign packet_drop = drop_r;
	assign fund_reset_req = fund_r;
	assign core_hold = hold_r || reset_op;
	assign write_unlock = unlock_r;
	assign strict_ordering_force = strict_r;
	assign unsupported_cpl_enable = uc_en_r;

	property p_swrst;
		@(posedge clk) disable iff (rst) (wr_ctl && req.wdata[`BIT_SWRST] && !hot_rst) |=> fund_reset_req;
	endproperty
	a_swrst: assert property (p_swrst) else $error("no reset pulse");
	property p_rd_zero;
		@(posedge clk) disable iff (rst) rd_ctl |=> rdata[`BIT_SWRST] == 1'b0;
	endproperty
	a_rd_zero: assert property (p_rd_zero) else $error("reset bit reads one");
	property p_hold;
		@(posedge clk) disable iff (rst) hold_r |-> core_hold;
	endproperty
	a_hold: assert property (p_hold) else $error("hold not applied");
	property p_unlock_op;
		@(posedge clk) disable iff (rst || hot_rst) reset_op |=> write_unlock;
	endproperty
	a_unlock_op: assert property (p_unlock_op) else $error("unlock not set");
	property p_hot_sticky;
		@(posedge clk) disable iff (rst) (hot_rst && !wr_sts) |=> $stable(marker_r) && $stable(uc_en_r);
	endproperty
	a_hot_sticky: assert property (p_hot_sticky) else $error("sticky lost");
	property p_drop;
		@(posedge clk) disable iff (rst) drop_set |=> drop_q && packet_drop;
	endproperty
	a_drop: assert property (p_drop) else $error("drop flag missing");
	property p_discard_err;
		@(posedge clk) disable iff (rst) (discard_set && err_report_en) |=> discard_q && err_nonfatal;
	endproperty
	a_discard_err: assert property (p_discard_err) else $error("discard error missing");
	property p_pme;
		@(posedge clk) disable iff (rst) pme_set |=> pme_q;
	endproperty
	a_pme: assert property (p_pme) else $error("pme flag missing");
	property p_strict;
		@(posedge clk) disable iff (rst || hot_rst) wr_ctl |=> strict_ordering_force == $past(req.wdata[`BIT_STRICT]);
	endproperty
	a_strict: assert property (p_strict) else $error("strict bit wrong");

	// reset sequencing and hold
	sequence s_swrst_wr;
		wr_ctl && req.wdata[`BIT_SWRST] && !hot_rst;
	endsequence
	sequence s_op_window;
		fund_reset_req ##1 core_hold [*8];
	endsequence
	property p_fund_hold;
		@(posedge clk) disable iff (rst) s_swrst_wr |=> s_op_window;
	endproperty
	a_fund_hold: assert property (p_fund_hold) else $error("reset window missing");
	property p_hold_pin;
		@(posedge clk) disable iff (rst) hold_pin_set |=> hold_r;
	endproperty
	a_hold_pin: assert property (p_hold_pin) else $error("pin hold missed");
	property p_hold_eeprom;
		@(posedge clk) disable iff (rst) (eeprom_hold_wr && !hold_pin_set)
			|=> hold_r == $past(eeprom_hold_val);
	endproperty
	a_hold_eeprom: assert property (p_hold_eeprom) else $error("eeprom hold missed");
	property p_hold_release;
		@(posedge clk) disable iff (rst) (hold_sw_ok && !hold_pin_set && !eeprom_hold_wr)
			|=> hold_r == $past(req.wdata[`BIT_HOLD]);
	endproperty
	a_hold_release: assert property (p_hold_release) else $error("hold write lost");
	property p_hold_ignored;
		@(posedge clk) disable iff (rst) (wr_ctl && !hold_sw_ok && !eeprom_hold_wr) |=> $stable(hold_r);
	endproperty
	a_hold_ignored: assert property (p_hold_ignored) else $error("late hold write taken");

	// control bit checks
	property p_unlock_wr;
		@(posedge clk) disable iff (rst || hot_rst) (wr_ctl && !reset_op)
			|=> write_unlock == $past(req.wdata[`BIT_UNLOCK]);
	endproperty
	a_unlock_wr: assert property (p_unlock_wr) else $error("unlock write lost");
	property p_unlock_keep;
		@(posedge clk) disable iff (rst || hot_rst) (!wr_ctl && !reset_op) |=> $stable(write_unlock);
	endproperty
	a_unlock_keep: assert property (p_unlock_keep) else $error("unlock changed unasked");
	property p_hot_ctl;
		@(posedge clk) disable iff (rst) hot_rst |=> !write_unlock && !strict_ordering_force && !fund_reset_req;
	endproperty
	a_hot_ctl: assert property (p_hot_ctl) else $error("control kept over hot reset");
	property p_strict_keep;
		@(posedge clk) disable iff (rst || hot_rst) !wr_ctl |=> $stable(strict_ordering_force);
	endproperty
	a_strict_keep: assert property (p_strict_keep) else $error("strict changed unasked");

	// status write and read checks
	property p_uc_en;
		@(posedge clk) disable iff (rst) wr_sts
			|=> unsupported_cpl_enable == $past(req.wdata[`BIT_UC_EN]);
	endproperty
	a_uc_en: assert property (p_uc_en) else $error("completion enable lost");
	property p_marker_rd;
		@(posedge clk) disable iff (rst) rd_sts
			|=> rdata[`POS_MARKER +: 3] == $past(marker_r) && rdata[`BIT_UC_EN] == $past(uc_en_r);
	endproperty
	a_marker_rd: assert property (p_marker_rd) else $error("sticky read wrong");
	property p_lock_rd;
		@(posedge clk) disable iff (rst) rd_sts |=> rdata[`POS_LOCK +: 2] == $past(lock_state);
	endproperty
	a_lock_rd: assert property (p_lock_rd) else $error("lock state read wrong");
	property p_int_rd;
		@(posedge clk) disable iff (rst) rd_sts |=> rdata[`POS_INT +: 4] == $past(int_state);
	endproperty
	a_int_rd: assert property (p_int_rd) else $error("interrupt state read wrong");
	property p_maxw_rd;
		@(posedge clk) disable iff (rst) rd_sts |=> rdata[`POS_MAX_WIDTH +: 2] == `RST_MAX_WIDTH;
	endproperty
	a_maxw_rd: assert property (p_maxw_rd) else $error("width field read wrong");
	property p_rd_other;
		@(posedge clk) disable iff (rst) (req.rd && !rd_sts && !rd_ctl) |=> rdata == 32'h00000000;
	endproperty
	a_rd_other: assert property (p_rd_other) else $error("unmapped read not zero");
	property p_rdata_stand;
		@(posedge clk) disable iff (rst) !req.rd |=> $stable(rdata);
	endproperty
	a_rdata_stand: assert property (p_rdata_stand) else $error("read data moved");

	// lock flag checks
	property p_foreign;
		@(posedge clk) disable iff (rst) (is_locked && evt.foreign_mrdlk) |=> drop_q;
	endproperty
	a_foreign: assert property (p_foreign) else $error("foreign locked read kept");
	property p_drop_keep;
		@(posedge clk) disable iff (rst) (drop_q && !clr_drop) |=> drop_q;
	endproperty
	a_drop_keep: assert property (p_drop_keep) else $error("drop flag lost");
	property p_drop_clear;
		@(posedge clk) disable iff (rst) (clr_drop && !drop_set) |=> !drop_q;
	endproperty
	a_drop_clear: assert property (p_drop_clear) else $error("drop flag not cleared");
	property p_no_drop;
		@(posedge clk) disable iff (rst) !(drop_set || discard_set) |=> !packet_drop;
	endproperty
	a_no_drop: assert property (p_no_drop) else $error("spurious drop");
	property p_pme_err;
		@(posedge clk) disable iff (rst) (pme_set && err_report_en) |=> err_nonfatal;
	endproperty
	a_pme_err: assert property (p_pme_err) else $error("pme error missing");
	property p_err_off;
		@(posedge clk) disable iff (rst) !err_report_en |=> !err_nonfatal;
	endproperty
	a_err_off: assert property (p_err_off) else $error("error sent while disabled");
	property p_unlocked_quiet;
		@(posedge clk) disable iff (rst) !is_locked |=> !packet_drop && !err_nonfatal;
	endproperty
	a_unlocked_quiet: assert property (p_unlocked_quiet) else $error("drop while unlocked");
endmodule // switch_lock_status_control

// *** design/w1c_flag.sv ***
`timescale 1ns/1ns
module w1c_flag
	import sw_lock_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic set,
	input wire logic clr,
	output logic q
);
	logic q_nxt;
	assign q_nxt = set ? 1'b1 : (clr ? 1'b0 : q);
	always_ff @(posedge clk) begin
		if (rst) begin
			q <= 1'b0;
		end else begin
			q <= q_nxt;
		end
	end
	property p_set_wins;
		@(posedge clk) disable iff (rst) set |=> q;
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("flag lost on set");
	property p_w1c_clear;
		@(posedge clk) disable iff (rst) (clr && !set) |=> !q;
	endproperty
	a_w1c_clear: assert property (p_w1c_clear) else $error("flag not cleared");
	property p_w1c_keep;
		@(posedge clk) disable iff (rst) (!set && !clr) |=> q == $past(q);
	endproperty
	a_w1c_keep: assert property (p_w1c_keep) else $error("flag changed unasked");
endmodule // w1c_flag

// *** sim/config_root.sv ***
`timescale 1ns/1ns
module config_root
	import sw_lock_pkg::*;
(
	input wire logic clk,
	input wire logic [31:0] rdata,
	output reg_req_t req
);
	initial req = '0;
	// one strobe, held over one edge, then idle
	task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
		req <= '{w, !w, a, d};
		@(posedge clk);
		#1 req <= '0;
		@(posedge clk);
		#1 q = rdata;
	endtask
endmodule // config_root

// *** sim/test_switch_lock_status_control.sv ***
`timescale 1ns/1ns
module test_switch_lock_status_control;
	import sw_lock_pkg::*;
	logic clk = 0, rst = 1, hot_rst = 0, seen_err = 0, seen_frq = 0;
	logic hold_pin = 0, ee_wr = 0, ee_val = 0, err_en = 1, seen_drop = 0;
	lock_state_t lock_state = LOCK_NONE;
	lock_evt_t evt = '0;
	logic [3:0] int_state = 4'h0;
	reg_req_t req;
	logic [31:0] rdata, q, d, seed = 32'hea77e219;
	logic err_nonfatal, packet_drop, fund_reset_req, core_hold, write_unlock, strict_ordering_force, uc_en;
	int failures = 0, checks = 0;
	int bp[4] = '{25, 24, 19, 19};
	switch_lock_status_control u_dut(.clk(clk), .rst(rst), .hot_rst(hot_rst), .reset_hold_pin(hold_pin),
		.eeprom_hold_wr(ee_wr), .eeprom_hold_val(ee_val), .req(req), .rdata(rdata), .lock_state(lock_state),
		.evt(evt), .err_report_en(err_en), .int_state(int_state), .err_nonfatal(err_nonfatal),
		.packet_drop(packet_drop), .fund_reset_req(fund_reset_req), .core_hold(core_hold),
		.write_unlock(write_unlock), .strict_ordering_force(strict_ordering_force),
		.unsupported_cpl_enable(uc_en));
	config_root u_root(.clk(clk), .rdata(rdata), .req(req));
	initial forever #25 clk = ~clk;
	always @(posedge clk) begin
		if (err_nonfatal === 1'b1) seen_err <= 1'b1;
		if (fund_reset_req === 1'b1) seen_frq <= 1'b1;
		if (packet_drop === 1'b1) seen_drop <= 1'b1;
	end
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// status bits 31:13 with no flag raised
	function automatic logic [18:0] exp_stat(input logic [3:0] ints, input lock_state_t l, input logic [3:0] um);
		return {8'h00, ints, 1'b0, l, um};
	endfunction
	task automatic chk(input logic ok, input string m);
		checks++;
		if (ok !== 1'b1) begin
			failures++;
			$display("unexpected at %0t: %s", $time, m);
		end
	endtask
	task automatic complete_run();
		$display("failures %0d checks %0d", failures, checks);
		if (failures == 0 && checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		#2000000;
		failures++;
		complete_run();
	end
	initial begin
		repeat (12) @(posedge clk);
		#1 rst = 0;
		repeat (10) @(posedge clk);
		#1 chk(write_unlock === 1'b1 && core_hold === 1'b0, "unlock after reset op");
		repeat (6) begin
			d = xs();
			lock_state = (d[1:0] == 2'h3) ? LOCK_NONE : lock_state_t'(d[1:0]);
			int_state = d[7:4];
			u_root.acc(1, 12'h0a0, d & 32'h0001e000, q);
			u_root.acc(1, 12'h0a4, {28'h0, d[9:8], 2'h0}, q);
			u_root.acc(0, 12'h0a0, 0, q);
			chk(q[31:13] === exp_stat(d[7:4], lock_state, d[16:13]), "status fields");
			chk(uc_en === d[13], "completion enable");
			u_root.acc(0, 12'h0a4, 0, q);
			chk(q[3:0] === {d[9:8], 2'h0} && strict_ordering_force === d[9], "control bits");
			chk(write_unlock === d[8], "unlock level");
			hot_rst = 1;
			@(posedge clk);
			#1 hot_rst = 0;
			u_root.acc(0, 12'h0a0, 0, q);
			chk(q[31:13] === exp_stat(d[7:4], lock_state, d[16:13]) && uc_en === d[13], "sticky after hot reset");
		end
		lock_state = LOCK_PORT_B;
		for (int k = 0; k < 4; k++) begin
			seen_err = 0;
			seen_drop = 0;
			evt = lock_evt_t'(4'h1 << k);
			@(posedge clk);
			#1 evt = '0;
			u_root.acc(0, 12'h0a0, 0, q);
			chk(q[bp[k]] === 1'b1, "event flag");
			chk(seen_drop === (k > 0), "drop pulse");
			if (k < 2) chk(seen_err === 1'b1, "error message");
			u_root.acc(1, 12'h0a0, 32'h1 << bp[k], q);
			u_root.acc(0, 12'h0a0, 0, q);
			chk(q[bp[k]] === 1'b0, "flag clear");
		end
		hold_pin = 1;
		u_root.acc(1, 12'h0a4, 32'h1, q);
		chk(seen_frq === 1'b1 && core_hold === 1'b1, "fundamental reset");
		repeat (10) @(posedge clk);
		#1 u_root.acc(0, 12'h0a4, 0, q);
		chk(q[0] === 1'b0 && write_unlock === 1'b1, "reset bit reads zero");
		hold_pin = 0;
		chk(q[1] === 1'b1 && core_hold === 1'b1, "hold from pin");
		u_root.acc(1, 12'h0a4, 32'h0, q);
		chk(core_hold === 1'b0, "hold released");
		u_root.acc(1, 12'h0a4, 32'h2, q);
		u_root.acc(0, 12'h0a4, 0, q);
		chk(q[1] === 1'b0 && core_hold === 1'b0, "hold write ignored");
		ee_val = 1;
		ee_wr = 1;
		@(posedge clk);
		#1 ee_wr = 0;
		chk(core_hold === 1'b1, "hold from eeprom");
		u_root.acc(1, 12'h0a4, 32'h0, q);
		u_root.acc(0, 12'h0a8, 0, q);
		chk(q === 32'h0 && core_hold === 1'b0, "other address");
		err_en = 0;
		lock_state = LOCK_PORT_C;
		seen_err = 0;
		evt = lock_evt_t'(4'h2);
		@(posedge clk);
		#1 evt = '0;
		u_root.acc(0, 12'h0a0, 0, q);
		chk(q[24] === 1'b1 && seen_err === 1'b0, "no error when disabled");
		complete_run();
	end
endmodule // test_switch_lock_status_control
